// ==== hdl/bitbr_cfg.svh ====
`ifndef BITBR_CFG_SVH
`define BITBR_CFG_SVH
`define OPC_BIT_CLEAR   4'h9
`define OPC_BRANCH_HI   4'hE
`define OPC_BR_NEGATIVE 4'h6
`define OPC_BR_CARRY    4'h2
`define ILO_LIMIT       8'h5F
`define PC_STEP         21'h000002
`define PC_RESET        21'h000000
`define PHASE_COUNT     2'h3
`endif

// ==== hdl/bitbr_pkg.sv ====
package bitbr_pkg;
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0]  data;
      logic        we;
      logic        re;
   } dmem_req_t;
   typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;
endpackage : bitbr_pkg

// ==== hdl/branch_and_bit_clear_exec.sv ====
// Functional notes
// RULE1: Bit clear zeroes one bit, keeps seven.
// RULE2: Access bit picks access bank or bank.
// RULE3: Extended mode indexes operands up to 5Fh.
// RULE4: Negative branch taken only when N set.
// RULE5: Offset signed, doubled, added to program counter.
// RULE6: Taken target is address plus two plus 2n.
// RULE7: Taken two cycles, untaken one cycle.
// RULE8: Carry branch jumps on C, else next word.
// RULE9: Carry branch decoded from its own opcode.
// RULE10: Flags untouched; every instruction one word.
// RULE11: Bit clear: read Q2, modify Q3, write Q4; code drives re on dmem_req_o in Q3, we in the next Q1.
`timescale 1ns/1ps
`default_nettype none
`include "bitbr_cfg.svh"
module branch_and_bit_clear_exec (
   // Clock and reset
   input  wire logic                clk_i,
   input  wire logic                reset_i,
   input  wire logic                clk_en_i,
   // Instruction and core state
   input  wire logic [15:0]         opcode_i,
   input  wire logic                opcode_valid_i,
   input  wire logic [5:0]          bank_select_register_i,
   input  wire logic [11:0]         index_base_i,
   input  wire logic                ext_set_en_i,
   input  wire logic                flag_negative_i,
   input  wire logic                flag_carry_i,
   // Data memory
   input  wire logic [7:0]          dmem_rdata_i,
   output var  bitbr_pkg::dmem_req_t dmem_req_o,
   // Program flow
   output logic [20:0]              program_counter_o,
   output logic                     branch_taken_o,
   output logic                     idle_cycle_o,
   output logic                     instr_done_o,
   output bitbr_pkg::phase_t        phase_o
);
   import bitbr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State
   phase_t     phase_q, phase_d;
   logic [15:0] ir_q, ir_d;
   logic [20:0] pc_q, pc_d;
   logic        flush_q, flush_d;
   logic        taken_q, taken_d;
   logic        done_q, done_d;
   logic [7:0]  work_q, work_d;
   dmem_req_t   req_q, req_d;

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   logic        is_clear, is_neg_br, is_carry_br, cond_met;
   logic [2:0]  bit_sel;
   logic        acc_sel;
   logic [7:0]  freg;
   logic [11:0] ea;
   logic [20:0] offset_x2;

   always_comb begin
      is_clear    = (ir_q[15:12] == `OPC_BIT_CLEAR); // RULE1
      is_neg_br   = (ir_q[15:12] == `OPC_BRANCH_HI) && (ir_q[11:8] == `OPC_BR_NEGATIVE); // RULE4
      is_carry_br = (ir_q[15:12] == `OPC_BRANCH_HI) && (ir_q[11:8] == `OPC_BR_CARRY); // RULE9
      bit_sel     = ir_q[11:9]; // RULE1
      acc_sel     = ir_q[8];
      freg        = ir_q[7:0];
      cond_met    = (is_neg_br && flag_negative_i) || (is_carry_br && flag_carry_i); // RULE4 RULE8
      // Sign-extend and double the offset
      offset_x2   = {{12{ir_q[7]}}, ir_q[7:0], 1'b0}; // RULE5
   end

   ////////////////////////////////////////////////////////////////////////////
   // Operand address
   // Bank mode honours only the low four bank bits, so 4K of data space
   always_comb begin
      if (acc_sel) begin
         ea = {bank_select_register_i[3:0], freg}; // RULE2
      end else if (ext_set_en_i && (freg <= `ILO_LIMIT)) begin
         ea = index_base_i + {4'h0, freg}; // RULE3
      end else if (freg[7]) begin
         ea = {4'hF, freg}; // RULE2
      end else begin
         ea = {4'h0, freg}; // RULE2
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_comb begin
      phase_d = phase_q;
      ir_d    = ir_q;
      flush_d = flush_q;
      taken_d = taken_q;
      done_d  = 1'b0;
      case (phase_q)
         PH_Q1: begin
            // An opcode offered during the idle cycle is dropped, not held over
            if (!flush_q && opcode_valid_i) begin
               ir_d = opcode_i;
            end else begin
               ir_d = 16'h0000;
            end
            phase_d = PH_Q2;
         end
         PH_Q2: begin
            phase_d = PH_Q3;
         end
         PH_Q3: begin
            phase_d = PH_Q4;
         end
         PH_Q4: begin
            if (cond_met) begin
               flush_d = 1'b1; // RULE7
               taken_d = 1'b1; // RULE7
            end else begin
               flush_d = 1'b0; // RULE7
               taken_d = 1'b0;
               done_d  = flush_q || (ir_q != 16'h0000); // RULE11
            end
            phase_d = PH_Q1;
         end
         default: begin
            phase_d = PH_Q1;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         phase_q <= PH_Q1;
         ir_q    <= 16'h0000;
         flush_q <= 1'b0;
         taken_q <= 1'b0;
         done_q  <= 1'b0;
      end else if (clk_en_i) begin
         phase_q <= phase_d;
         ir_q    <= ir_d;
         flush_q <= flush_d;
         taken_q <= taken_d;
         done_q  <= done_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Program counter
   // Status flags are inputs only; no path here or below writes them
   always_comb begin
      pc_d = pc_q;
      if ((phase_q == PH_Q1) && !flush_q && opcode_valid_i) begin
         pc_d = pc_q + `PC_STEP; // RULE10
      end else if ((phase_q == PH_Q4) && cond_met) begin
         // pc_q already points past the branch word, which supplies the plus two
         pc_d = pc_q + offset_x2; // RULE5 RULE6 RULE8
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pc_q <= `PC_RESET;
      end else if (clk_en_i) begin
         pc_q <= pc_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data memory read-modify-write
   always_comb begin
      work_d     = work_q;
      req_d      = '0;
      req_d.addr = req_q.addr;
      case (phase_q)
         PH_Q2: begin
            if (is_clear) begin
               req_d.addr = ea;
               req_d.re   = 1'b1; // RULE11
            end
         end
         PH_Q3: begin
            if (is_clear) begin
               work_d = dmem_rdata_i & ~(8'h01 << bit_sel); // RULE1 RULE11
            end
         end
         PH_Q4: begin
            if (is_clear) begin
               req_d.data = work_q;
               req_d.we   = 1'b1; // RULE11
            end
         end
         default: begin
            req_d.we = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         work_q <= 8'h00;
         req_q  <= '0;
      end else if (clk_en_i) begin
         work_q <= work_d;
         req_q  <= req_d;
      end
   end

   assign dmem_req_o        = req_q;
   assign program_counter_o = pc_q;
   assign branch_taken_o    = taken_q;
   assign idle_cycle_o      = flush_q;
   assign instr_done_o      = done_q;
   assign phase_o           = phase_q;
endmodule : branch_and_bit_clear_exec
`default_nettype wire

// ==== verification/bitbr_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module bitbr_sva (
   // Watched ports
   input wire logic                 clk_i,
   input wire logic                 reset_i,
   input wire logic                 clk_en_i,
   input wire logic [15:0]          opcode_i,
   input wire logic [7:0]           dmem_rdata_i,
   input wire bitbr_pkg::dmem_req_t dmem_req_o,
   input wire logic                 branch_taken_o,
   input wire logic                 idle_cycle_o,
   input wire bitbr_pkg::phase_t    phase_o
);
   import bitbr_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   ////////////////////////////////////////////////////////////////////////////////
   ph_step_a: assert property (clk_en_i |=> phase_o == phase_t'($past(phase_o) + 2'h1))
      else $error("phase");
   read_ph_a: assert property (dmem_req_o.re |-> phase_o == PH_Q3) else $error("re");
   re_once_a: assert property (dmem_req_o.re |=> !dmem_req_o.re) else $error("re");
   write_ph_a: assert property (dmem_req_o.we |-> phase_o == PH_Q1 && $past(dmem_req_o.re, 2))
      else $error("we");
   clear_bit_a: assert property (dmem_req_o.we |-> dmem_req_o.data ==
      ($past(dmem_rdata_i, 2) & ~(8'h01 << $past(opcode_i[11:9], 4)))) else $error("data");
   idle_len_a: assert property ($rose(idle_cycle_o) |-> phase_o == PH_Q1 ##0
      idle_cycle_o [*4] ##1 !idle_cycle_o) else $error("idle");
   idle_src_a: assert property ($rose(idle_cycle_o) |->
      $past(opcode_i[15:8], 4) inside {8'hE6, 8'hE2}) else $error("idle");
   idle_flag_a: assert property (idle_cycle_o |-> branch_taken_o) else $error("taken");
   freeze_hold_a: assert property (!clk_en_i |=> $stable(phase_o) && $stable(dmem_req_o))
      else $error("freeze");
endmodule : bitbr_sva
bind branch_and_bit_clear_exec bitbr_sva chk (.*);
`default_nettype wire

// ==== verification/test_branch_and_bit_clear_exec.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_branch_and_bit_clear_exec;
   import bitbr_pkg::*;
   logic        clk_i = 0, reset_i = 1, vld = 0, en = 1, ext, fn, fc, idle, taken, done, tk;
   logic        nop_seen = 0;
   logic [5:0]  bank;
   logic [7:0]  rd, f;
   logic [11:0] ib;
   logic [15:0] opc = 0;
   logic [20:0] prog, exp_prog = 0;
   logic [42:0] q[$], x, y;
   phase_t      ph;
   dmem_req_t   req;
   int          error_cnt = 0, total_checks = 0, seed = 32'hab5b, k, w;
   always #5 clk_i = ~clk_i;
   branch_and_bit_clear_exec dut (.clk_i, .reset_i, .clk_en_i(en), .opcode_i(opc),
      .opcode_valid_i(vld), .bank_select_register_i(bank), .index_base_i(ib), .ext_set_en_i(ext),
      .flag_negative_i(fn), .flag_carry_i(fc), .dmem_rdata_i(rd), .dmem_req_o(req),
      .program_counter_o(prog), .branch_taken_o(taken), .idle_cycle_o(idle),
      .instr_done_o(done), .phase_o(ph));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(string s, logic [42:0] a, b);
      total_checks++;
      if (a !== b) $display("CHECK FAILED %s expected %h seen %h", s, b, a);
      error_cnt += int'(a !== b);
   endtask : check
   task automatic complete_run;
      // Leftover notes count as mismatches
      error_cnt += q.size();
      if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run
   // Results land at the first non-idle Q1 after issue, so taken branches wait out the nop
   always @(negedge clk_i) begin
      if (!reset_i && ph === PH_Q1 && q.size() > 0) begin
         if (idle === 1'b1) begin
            check("taken", {taken, idle}, {2{q[0][42]}});
            nop_seen = 1;
         end else begin
            y = q.pop_front();
            check("idle", nop_seen, y[42]);
            check("done", {taken, done}, 2'b01);
            check("pc", prog, y[41:21]);
            check("write", {req.we, y[20] ? {req.addr, req.data} : 20'h0}, y[20:0]);
            nop_seen = 0;
         end
      end
   end
   initial begin
      {rd, ib, bank, ext, fn, fc} = '0;
      repeat (2) @(negedge clk_i);
      reset_i = 0;
      for (int i = 0; i < 90; i++) begin
         k = 0;
         while (k++ < 80 && {ph, q.size() > 0} !== {PH_Q1, 1'b0}) begin
            // Freezes stay out of the idle cycle and off the opcode-sampling edge
            en = !(ph === PH_Q2 && idle === 1'b0 && ($random(seed) & 3) == 0);
            @(negedge clk_i);
         end
         if (k > 80) begin
            error_cnt++;
            break;
         end
         {rd, ib, bank, ext, fn, fc} = 29'($random(seed));
         w = $random(seed);
         // Early bit clears straddle the indexed-offset limit
         f = i < 12 ? 8'h5E + 8'(i / 3) : w[7:0];
         exp_prog += 21'h2;
         if (i % 3 == 0) begin
            opc = {4'h9, w[11:8], f};
            x = {2'b00, exp_prog, 1'b1,
               w[8] ? {bank[3:0], f} : ext && f <= 8'h5F ? ib + 12'(f) : {{4{f[7]}}, f},
               rd & ~(8'h01 << w[11:9])};
         end else begin
            opc = {4'hE, i % 3 == 1 ? 4'h6 : 4'h2, w[23:16]};
            tk = i % 3 == 1 ? fn : fc;
            if (tk) exp_prog += {{12{w[23]}}, w[23:16], 1'b0};
            x = {tk, exp_prog, 21'h0};
         end
         vld = 1;
         @(negedge clk_i);
         vld = 0;
         q.push_back(x);
      end
      for (k = 0; k < 20 && q.size() > 0; k++) @(negedge clk_i);
      complete_run;
   end
endmodule : test_branch_and_bit_clear_exec
`default_nettype wire
